// ### fps_flash_model.sv
`timescale 1ns/1ns
module fps_flash_model #(
  parameter int PROG_NS = 3000,
  parameter logic [7:0] PROG = 8'h11,
  parameter logic [7:0] CFG = 8'h22,
  parameter logic [7:0] SEAL = 8'h33,
  parameter logic [7:0] SEALB = 8'h77,
  parameter logic [7:0] ID = 8'h44,
  parameter logic [7:0] EXIT = 8'h66
) (
  input wire logic [fps_pkg::ADDR_W-1:0] addr,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic rstN,
  input wire logic [fps_pkg::DATA_W-1:0] din,
  input wire logic vppLow,
  output logic [fps_pkg::DATA_W-1:0] dout
);
  import fps_pkg::*;
  logic [15:0] mem [16];
  logic [15:0] ld = 16'h0, last = 16'h0, rd;
  logic [19:0] la = 20'h0;
  logic [3:0] locked = 4'h0;
  logic [1:0] cfg = CFG_RESET;
  logic [1:0] arm = 2'h0;
  logic busyF = 1'b0, statMode = 1'b0, idMode = 1'b0, failF = 1'b0, lowF = 1'b0, tog = 1'b0;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
  always_comb begin
    if (busyF) rd = {8'h00, (cfg == CFG_HOLD) ? 1'b0 : ~ld[7], tog, 6'h00};
    else if (statMode) rd = {8'h00, 1'b1, tog, failF, 1'b0, lowF, 3'h0};
    else if (idMode) rd = {15'h0, addr[1:0] == 2'h2 && locked[addr[3:2]]};
    else rd = mem[addr[3:0]];
  end
  // Released bus shows the inverse so stale data never passes for a read
  assign dout = (ceN || oeN || !rstN) ? ~last : rd;
  always @(posedge oeN) last = rd;
  always @(negedge oeN) if (!ceN && busyF) tog = ~tog;
  always @(negedge weN) if (!ceN) la = addr;
  always @(posedge weN) begin
    if (!ceN && rstN && !busyF) begin
      if (arm == 2'h1) begin
        arm = 2'h0;
        ld = din;
        if (locked[la[3:2]] || vppLow) begin
          statMode = 1'b1;
          failF = 1'b1;
          lowF = vppLow;
        end else busyF = 1'b1;
      end else if (arm == 2'h2) begin
        arm = 2'h0;
        cfg = din[1:0];
      end else if (din[7:0] == EXIT) {statMode, idMode, failF, lowF} = 4'h0;
      else if (arm == 2'h3 && din[7:0] == SEALB) locked[la[3:2]] = 1'b1;
      else if (din[7:0] == ID) idMode = 1'b1;
      else if (din[7:0] == PROG) arm = 2'h1;
      else if (din[7:0] == CFG) arm = 2'h2;
      else if (din[7:0] == SEAL) arm = 2'h3;
    end
  end
  always @(posedge busyF) begin
    #(PROG_NS);
    if (busyF) begin
      failF = |(ld & ~mem[la[3:0]]);
      mem[la[3:0]] = mem[la[3:0]] & ld;
      statMode = failF || cfg == CFG_HOLD;
      busyF = 1'b0;
    end
  end
  // Configuration survives the pin, locks do not
  always @(negedge rstN) begin
    if (busyF) mem[la[3:0]] = ~ld;
    {busyF, statMode, idMode, failF, lowF, arm, locked} = '0;
  end
endmodule

// ### fps_host_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Program uses unlock cycles plus target write
// RULE2 - Never issue commands while operation runs
// RULE3 - Refuse programs that would raise zero bits
// RULE4 - Flash reset pin frozen during operations
// RULE5 - Config 01 needs exit after success
// RULE6 - Failure always followed by exit command
// RULE7 - Configuration shadow starts at 00
// RULE8 - Flash reset pin leaves configuration alone
// RULE9 - Configuration changed by its own sequence
// RULE10 - Config 00 success means true data back
// RULE11 - Erase reads show zero polling bit
// RULE12 - Config 01 polling bit high when finished
// RULE13 - Next cycle only after true completion
// RULE14 - Completion detected when toggle bit stops
// RULE15 - Failure bit reported as operation failure
// RULE16 - Raising zero bits may flag failure
// RULE17 - Locked sector write ends in failure status
// RULE18 - Failure bit trusted only after recheck
// RULE19 - Supply low reported, then exit issued
// RULE20 - Device reset unlocks every sector
// RULE21 - Lock uses six cycle raw sequence
// RULE22 - Lock flag read from data bit zero
// RULE23 - Only reset or power-up unlocks sectors
// RULE24 - Address before write strobe, data past rise
module fps_host_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [fps_pkg::ADDR_W-1:0] flashAddr,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic flashRstN,
  output logic [fps_pkg::DATA_W-1:0] dqOut,
  output logic dqOeN,
  input wire logic [fps_pkg::DATA_W-1:0] dqIn,
  output logic busy
);
  import fps_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_SEND, S_TARGET, S_POLL, S_EXIT, S_READ
  } fps_state_e;

  fps_state_e stateReg;
  logic [2:0] opReg;
  logic [7:0] addrReg;
  logic wrPendReg;
  logic [ADDR_W-1:0] tgtAddrReg;
  logic [DATA_W-1:0] tgtDataReg;
  logic [ADDR_W-1:0] exitAddrReg;
  logic [DATA_W-1:0] exitDataReg;
  logic [IDX_W-1:0] seqCntReg;
  logic [IDX_W-1:0] seqIdxReg;
  logic [1:0] cfgReg;
  logic [1:0] cfgReqReg;
  logic holdRstReg;
  logic doneReg;
  logic failReg;
  logic supplyReg;
  logic refusedReg;
  logic [DATA_W-1:0] prevReg;
  logic firstReg;
  logic failCandReg;
  logic [2:0] phaseReg;
  logic cycWrReg;
  logic [DATA_W-1:0] cycRdataReg;

  logic wrEn;
  logic go;
  logic [2:0] goOp;
  logic zeroSeq;
  logic seqHit;
  logic cycReq;
  logic cycWrite;
  logic cycDone;
  logic [ADDR_W-1:0] cycAddr;
  logic [DATA_W-1:0] cycData;
  logic refusedNow;
  logic lastSeq;
  logic toggling;
  logic statBits;
  logic finalFail;
  logic pollNow;
  logic failSet;
  logic finishing;
  logic [31:0] statusWord;
  logic [IDX_W-1:0] cntIn;

  fps_seq_if seqBus ();

  fps_seq_mem uMem (
    .clk(clk),
    .port(seqBus.mem)
  );

  // Bus slave: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = stateReg != S_IDLE;
  assign flashRstN = !holdRstReg;

  // Writes are dropped while busy so an operation sees stable settings
  assign wrEn = wrPendReg && stateReg == S_IDLE; // see RULE2
  assign go = wrEn && addrReg == OFF_CTRL && hwdata[CTRL_GO_BIT];
  assign goOp = hwdata[CTRL_OP_LSB +: 3];
  assign zeroSeq = (goOp == OP_SEQ || goOp == OP_CFG) && seqCntReg == SEQCNT_RESET;
  assign seqHit = addrReg[7:6] == SEQ_WIN && addrReg[5:3] < IDX_W'(SEQ_DEPTH);
  assign cntIn = hwdata[IDX_W-1:0] > IDX_W'(SEQ_DEPTH) ? IDX_W'(SEQ_DEPTH) : hwdata[IDX_W-1:0];

  assign seqBus.weAddr = wrEn && seqHit && !addrReg[2];
  assign seqBus.weData = wrEn && seqHit && addrReg[2];
  assign seqBus.wIdx = addrReg[5:3];
  assign seqBus.wWord = hwdata[ADDR_W-1:0];
  assign seqBus.rIdx = seqIdxReg;

  always_comb begin
    statusWord = 32'h0;
    statusWord[ST_BUSY] = busy;
    statusWord[ST_DONE] = doneReg;
    statusWord[ST_FAIL] = failReg;
    statusWord[ST_SUPPLY] = supplyReg;
    statusWord[ST_REFUSED] = refusedReg;
    statusWord[ST_CFG_LSB +: 2] = cfgReg;
    statusWord[ST_LOCK] = cycRdataReg[LOCK_FLAG_BIT]; // see RULE22
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrReg <= 8'h00;
      wrPendReg <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      wrPendReg <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        addrReg <= haddr[7:0];
        wrPendReg <= hwrite && hsize == 3'h2;
        hrdata <= 32'h0;
        if (!hwrite) begin
          case (haddr[7:0])
            OFF_CTRL: hrdata <= {22'h0, cfgReqReg, 3'h0, holdRstReg, opReg, 1'b0};
            OFF_STATUS: hrdata <= statusWord;
            OFF_TADDR: hrdata <= {12'h0, tgtAddrReg};
            OFF_TDATA: hrdata <= {16'h0, tgtDataReg};
            OFF_RDATA: hrdata <= {16'h0, cycRdataReg};
            OFF_SEQCNT: hrdata <= {29'h0, seqCntReg};
            OFF_EXITA: hrdata <= {12'h0, exitAddrReg};
            OFF_EXITD: hrdata <= {16'h0, exitDataReg};
            default: hrdata <= 32'h0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgtAddrReg <= ADDR_RESET;
      tgtDataReg <= DATA_RESET;
      exitAddrReg <= ADDR_RESET;
      exitDataReg <= DATA_RESET;
      seqCntReg <= SEQCNT_RESET;
      cfgReqReg <= CFG_RESET;
      holdRstReg <= 1'b0;
    end else if (wrEn) begin
      case (addrReg)
        OFF_CTRL: begin
          holdRstReg <= hwdata[CTRL_RST_BIT]; // see RULE4 see RULE20 see RULE23
          cfgReqReg <= hwdata[CTRL_CFG_LSB +: 2];
        end
        OFF_TADDR: tgtAddrReg <= hwdata[ADDR_W-1:0];
        OFF_TDATA: tgtDataReg <= hwdata[DATA_W-1:0];
        OFF_SEQCNT: seqCntReg <= cntIn;
        OFF_EXITA: exitAddrReg <= hwdata[ADDR_W-1:0];
        OFF_EXITD: exitDataReg <= hwdata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // What each state puts on the pins
  always_comb begin
    cycReq = stateReg != S_IDLE;
    cycWrite = stateReg == S_SEND || stateReg == S_TARGET || stateReg == S_EXIT;
    cycAddr = tgtAddrReg;
    cycData = tgtDataReg;
    case (stateReg)
      S_SEND: begin
        cycAddr = seqBus.rdata[ADDR_W+DATA_W-1:DATA_W]; // see RULE21 see RULE9
        cycData = seqBus.rdata[DATA_W-1:0];
      end
      S_EXIT: begin
        cycAddr = exitAddrReg;
        cycData = exitDataReg;
      end
      default: ;
    endcase
  end

  assign cycDone = phaseReg == PH_END;

  // Pin cycle: gap lets the sequence memory settle, write strobe is one clock wide, output enable two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseReg <= PH_IDLE;
      flashAddr <= ADDR_RESET;
      dqOut <= DATA_RESET;
      dqOeN <= 1'b1;
      flashCeN <= 1'b1;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      cycWrReg <= 1'b0;
      cycRdataReg <= DATA_RESET;
    end else begin
      case (phaseReg)
        PH_IDLE: if (cycReq) begin
          phaseReg <= PH_GAP;
        end
        PH_GAP: begin
          flashAddr <= cycAddr;
          dqOut <= cycData;
          cycWrReg <= cycWrite;
          dqOeN <= !cycWrite;
          flashCeN <= 1'b0;
          phaseReg <= PH_SETUP;
        end
        PH_SETUP: begin
          if (cycWrReg) begin
            flashWeN <= 1'b0; // see RULE24
          end else begin
            flashOeN <= 1'b0;
          end
          phaseReg <= PH_STROBE;
        end
        PH_STROBE: begin
          flashWeN <= 1'b1; // see RULE24
          phaseReg <= PH_HOLD;
        end
        PH_HOLD: begin
          if (!cycWrReg) begin
            cycRdataReg <= dqIn;
          end
          flashOeN <= 1'b1;
          phaseReg <= PH_END;
        end
        PH_END: begin
          flashCeN <= 1'b1;
          dqOeN <= 1'b1;
          phaseReg <= PH_IDLE;
        end
        default: phaseReg <= PH_IDLE;
      endcase
    end
  end

  assign refusedNow = (tgtDataReg & ~cycRdataReg) != DATA_RESET; // see RULE3 see RULE16
  assign lastSeq = seqIdxReg == seqCntReg - IDX_W'(1);
  assign toggling = cycRdataReg[TOGGLE_STATUS_BIT] != prevReg[TOGGLE_STATUS_BIT]; // see RULE14
  assign statBits = cycRdataReg[OP_FAIL_BIT] || cycRdataReg[SUPPLY_LOW_BIT]; // see RULE15
  // Config 00 reads back data; config 01 shows status until exit
  assign finalFail = cfgReg == CFG_AUTO ? cycRdataReg != tgtDataReg // see RULE10 see RULE11
                                         : statBits || !cycRdataReg[POLL_STATUS_BIT]; // see RULE12
  assign pollNow = cycDone && stateReg == S_POLL && !firstReg;
  // A failure bit seen while toggling is trusted only on a second read
  assign failSet = pollNow && (toggling ? statBits && failCandReg : finalFail); // see RULE18
  assign finishing = cycDone && (stateReg == S_EXIT || stateReg == S_READ
    || (stateReg == S_CHECK && refusedNow)
    || (stateReg == S_SEND && lastSeq && opReg != OP_PROG)
    || (pollNow && !toggling && !finalFail && cfgReg != CFG_HOLD));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg <= S_IDLE;
      opReg <= OP_SEQ;
      seqIdxReg <= SEQCNT_RESET;
      firstReg <= 1'b1;
      failCandReg <= 1'b0;
      prevReg <= DATA_RESET;
    end else begin
      case (stateReg)
        S_IDLE: if (go) begin
          opReg <= goOp;
          seqIdxReg <= SEQCNT_RESET;
          firstReg <= 1'b1;
          failCandReg <= 1'b0;
          case (goOp)
            OP_PROG: stateReg <= S_CHECK;
            OP_READ: stateReg <= S_READ;
            OP_EXIT: stateReg <= S_EXIT;
            OP_SEQ, OP_CFG: stateReg <= zeroSeq ? S_IDLE : S_SEND;
            default: stateReg <= S_IDLE;
          endcase
        end
        S_CHECK: if (cycDone) begin
          if (refusedNow) begin
            stateReg <= S_IDLE;
          end else begin
            stateReg <= seqCntReg == SEQCNT_RESET ? S_TARGET : S_SEND;
          end
        end
        S_SEND: if (cycDone) begin
          if (lastSeq) begin
            stateReg <= opReg == OP_PROG ? S_TARGET : S_IDLE; // see RULE1
          end else begin
            seqIdxReg <= seqIdxReg + IDX_W'(1);
          end
        end
        S_TARGET: if (cycDone) begin
          stateReg <= S_POLL;
        end
        S_POLL: if (cycDone) begin
          firstReg <= 1'b0;
          prevReg <= cycRdataReg;
          if (!firstReg) begin
            if (toggling) begin
              failCandReg <= statBits;
              if (statBits && failCandReg) begin
                stateReg <= S_EXIT; // see RULE6 see RULE17
              end
            end else if (finalFail || cfgReg == CFG_HOLD) begin
              stateReg <= S_EXIT; // see RULE5 see RULE6 see RULE19
            end else begin
              stateReg <= S_IDLE; // see RULE13
            end
          end
        end
        S_EXIT, S_READ: if (cycDone) begin
          stateReg <= S_IDLE;
        end
        default: stateReg <= S_IDLE;
      endcase
    end
  end

  // Flags set while busy (done also by a go with an empty sequence) and cleared only by go, so the two never meet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneReg <= 1'b0;
      failReg <= 1'b0;
      supplyReg <= 1'b0;
      refusedReg <= 1'b0;
      cfgReg <= CFG_RESET; // see RULE7
    end else if (go) begin
      doneReg <= zeroSeq;
      failReg <= 1'b0;
      supplyReg <= 1'b0;
      refusedReg <= 1'b0;
      if (zeroSeq && goOp == OP_CFG) begin
        cfgReg <= hwdata[CTRL_CFG_LSB +: 2];
      end
    end else begin
      if (finishing) begin
        doneReg <= 1'b1;
      end
      if (finishing && opReg == OP_CFG) begin
        cfgReg <= cfgReqReg; // see RULE8 see RULE9
      end
      if (failSet) begin
        failReg <= 1'b1; // see RULE15 see RULE17
        supplyReg <= cycRdataReg[SUPPLY_LOW_BIT]; // see RULE19
      end
      if (cycDone && stateReg == S_CHECK && refusedNow) begin
        refusedReg <= 1'b1; // see RULE3
      end
    end
  end
endmodule

// ### fps_host_ctrl_props.sv
`timescale 1ns/1ns
module fps_host_ctrl_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [fps_pkg::ADDR_W-1:0] flashAddr,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic [fps_pkg::DATA_W-1:0] dqOut,
  input wire logic dqOeN,
  input wire logic flashRstN,
  input wire logic busy
);
  import fps_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_we_under_ce:
    assert property (!flashWeN |-> !flashCeN && flashOeN)
    else $error("write strobe outside chip enable");
  a_addr_first:
    assert property ($fell(flashWeN) |-> !$past(flashCeN) && $stable(flashAddr))
    else $error("address not settled at write strobe");
  a_we_pulse:
    assert property ($fell(flashWeN) |=> flashWeN && !flashCeN)
    else $error("write strobe not one cycle");
  a_data_hold:
    assert property ($rose(flashWeN) |-> !dqOeN && $stable(dqOut) && !flashCeN)
    else $error("data not held at strobe rise");
  a_ce_window:
    assert property ($fell(flashCeN) |-> ##4 $rose(flashCeN))
    else $error("chip enable window wrong");
  a_oe_pulse:
    assert property ($fell(flashOeN) |=> !flashOeN ##1 flashOeN)
    else $error("output enable not two cycles");
  a_no_contention:
    assert property (!flashOeN |-> dqOeN)
    else $error("data driven during read");
  a_rst_frozen:
    assert property (busy |=> $stable(flashRstN))
    else $error("flash reset moved during operation");
endmodule
bind fps_host_ctrl fps_host_ctrl_props u_fps_host_ctrl_props (.clk(clk), .rst(rst),
  .flashAddr(flashAddr), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
  .dqOut(dqOut), .dqOeN(dqOeN), .flashRstN(flashRstN), .busy(busy));

// ### fps_pkg.sv
package fps_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int SEQ_DEPTH = 6;
  localparam int IDX_W = 3;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TADDR = 8'h08;
  localparam logic [7:0] OFF_TDATA = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_SEQCNT = 8'h14;
  localparam logic [7:0] OFF_EXITA = 8'h18;
  localparam logic [7:0] OFF_EXITD = 8'h1c;
  localparam logic [1:0] SEQ_WIN = 2'h1;

  // Control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_RST_BIT = 4;
  localparam int CTRL_CFG_LSB = 8;

  // Operations
  localparam logic [2:0] OP_SEQ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_CFG = 3'h3;
  localparam logic [2:0] OP_EXIT = 3'h4;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_SUPPLY = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_CFG_LSB = 6;
  localparam int ST_LOCK = 8;

  // Device status bits on the data pins
  localparam int POLL_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int OP_FAIL_BIT = 5;
  localparam int SUPPLY_LOW_BIT = 3;
  localparam int LOCK_FLAG_BIT = 0;

  // Status mode configuration values
  localparam logic [1:0] CFG_AUTO = 2'h0;
  localparam logic [1:0] CFG_HOLD = 2'h1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [IDX_W-1:0] SEQCNT_RESET = 3'h0;

  // Pin cycle phases, one clock of 100 ns each
  localparam logic [2:0] PH_IDLE = 3'h0;
  localparam logic [2:0] PH_GAP = 3'h1;
  localparam logic [2:0] PH_SETUP = 3'h2;
  localparam logic [2:0] PH_STROBE = 3'h3;
  localparam logic [2:0] PH_HOLD = 3'h4;
  localparam logic [2:0] PH_END = 3'h5;
endpackage

// ### fps_seq_if.sv
`timescale 1ns/1ns
interface fps_seq_if;
  logic weAddr;
  logic weData;
  logic [fps_pkg::IDX_W-1:0] wIdx;
  logic [fps_pkg::ADDR_W-1:0] wWord;
  logic [fps_pkg::IDX_W-1:0] rIdx;
  logic [fps_pkg::ADDR_W+fps_pkg::DATA_W-1:0] rdata;
  modport ctrl (output weAddr, weData, wIdx, wWord, rIdx, input rdata);
  modport mem (input weAddr, weData, wIdx, wWord, rIdx, output rdata);
endinterface

// ### fps_seq_mem.sv
`timescale 1ns/1ns
module fps_seq_mem (
  input wire logic clk,
  fps_seq_if.mem port
);
  import fps_pkg::*;

  logic [ADDR_W-1:0] addrMem [SEQ_DEPTH];
  logic [DATA_W-1:0] dataMem [SEQ_DEPTH];

  for (genvar i = 0; i < SEQ_DEPTH; i++) begin : gEntry
    always_ff @(posedge clk) begin
      if (port.weAddr && port.wIdx == IDX_W'(i)) begin
        addrMem[i] <= port.wWord;
      end
      if (port.weData && port.wIdx == IDX_W'(i)) begin
        dataMem[i] <= port.wWord[DATA_W-1:0];
      end
    end
  end

  // Index is clamped by the reader, so no range check here
  always_ff @(posedge clk) begin
    port.rdata <= {addrMem[port.rIdx], dataMem[port.rIdx]};
  end
endmodule

// ### test_fps_host_ctrl.sv
`timescale 1ns/1ns
module test_fps_host_ctrl;
  import fps_pkg::*;
  localparam logic [7:0] CUNLK = 8'h55;
  localparam logic [7:0] CPROG = 8'h11;
  localparam logic [7:0] CCFG = 8'h22;
  localparam logic [7:0] CSEAL = 8'h33;
  localparam logic [7:0] CSEALB = 8'h77;
  localparam logic [7:0] CID = 8'h44;
  localparam logic [7:0] CEXIT = 8'h66;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, vppLow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, junk;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, busy, flashCeN, flashWeN, flashOeN, flashRstN, dqOeN;
  logic [ADDR_W-1:0] flashAddr;
  logic [DATA_W-1:0] dqOut, dqIn;
  int badCount = 0, totalChecks = 0, cyc = 0;
  always #50 clk = ~clk;
  fps_host_ctrl u_fps_host_ctrl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flashAddr(flashAddr),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashRstN(flashRstN),
    .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .busy(busy));
  fps_flash_model u_fps_flash_model (.addr(flashAddr), .ceN(flashCeN), .weN(flashWeN),
    .oeN(flashOeN), .rstN(flashRstN), .din(dqOeN ? dqIn : dqOut), .vppLow(vppLow),
    .dout(dqIn));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      stop_test();
    end
  end
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic ahbW(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, junk);
  endtask
  task automatic chkReg(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    totalChecks++;
    if ((q & m) !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, q & m);
    end
  endtask
  // Bounded wait; a stuck engine shows up as a wrong status later
  task automatic go(input logic [2:0] op, input logic [1:0] c);
    ahbW(OFF_CTRL, {22'h0, c, 4'h0, op, 1'b1});
    @(posedge clk);
    repeat (4000) if (busy !== 1'b0) @(posedge clk);
  endtask
  task automatic setSeq(input logic [95:0] s, input logic [2:0] n, input logic [19:0] a);
    for (int i = 0; i < int'(n); i++) begin
      ahbW(8'(8'h40 + 8 * i), {12'h0, a});
      ahbW(8'(8'h44 + 8 * i), {16'h0, s[16 * i +: 16]});
    end
    ahbW(OFF_SEQCNT, {29'h0, n});
  endtask
  task automatic prog(input logic [19:0] a, input logic [15:0] d);
    setSeq({48'h0, 8'h0, CPROG, 8'h0, CUNLK, 8'h0, CUNLK}, 3'h3, a);
    ahbW(OFF_TADDR, {12'h0, a});
    ahbW(OFF_TDATA, {16'h0, d});
    go(OP_PROG, 2'h0);
  endtask
  task automatic rdFlash(input logic [19:0] a, input logic [15:0] e);
    ahbW(OFF_TADDR, {12'h0, a});
    go(OP_READ, 2'h0);
    chkReg("flash data", OFF_RDATA, {16'h0, e}, 32'hffff);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chkReg("status", OFF_STATUS, 32'h0, 32'hff);
    ahbW(8'h30, 32'hffffffff);
    chkReg("unmapped", 8'h30, 32'h0, 32'hffffffff);
    ahbW(OFF_EXITD, {24'h0, CEXIT});
    $display("test reset finished");
    prog(20'h3, 16'h1234);
    chkReg("status", OFF_STATUS, 32'h2, 32'hff);
    rdFlash(20'h3, 16'h1234);
    prog(20'h3, 16'h1235);
    chkReg("status", OFF_STATUS, 32'h12, 32'hff);
    $display("test program finished");
    setSeq({32'h0, 16'h1, 8'h0, CCFG, 8'h0, CUNLK, 8'h0, CUNLK}, 3'h4, 20'h0);
    go(OP_CFG, 2'h1);
    prog(20'h4, 16'h0f0f);
    chkReg("status", OFF_STATUS, 32'h42, 32'hff);
    rdFlash(20'h4, 16'h0f0f);
    $display("test config finished");
    setSeq({8'h0, CSEALB, 8'h0, CUNLK, 8'h0, CUNLK, 8'h0, CSEAL, 8'h0, CUNLK, 8'h0, CUNLK},
      3'h6, 20'h4);
    go(OP_SEQ, 2'h0);
    prog(20'h5, 16'h0);
    chkReg("status", OFF_STATUS, 32'h46, 32'hff);
    rdFlash(20'h5, 16'hffff);
    setSeq({48'h0, 8'h0, CID, 8'h0, CUNLK, 8'h0, CUNLK}, 3'h3, 20'h0);
    go(OP_SEQ, 2'h0);
    rdFlash(20'h6, 16'h1);
    chkReg("lock flag", OFF_STATUS, 32'h100, 32'h100);
    rdFlash(20'h2, 16'h0);
    go(OP_EXIT, 2'h0);
    prog(20'h5, 16'h0);
    chkReg("status", OFF_STATUS, 32'h46, 32'hff);
    $display("test lockdown finished");
    ahbW(OFF_CTRL, 32'h10);
    ahbW(OFF_CTRL, 32'h0);
    prog(20'h5, 16'h0);
    chkReg("status", OFF_STATUS, 32'h42, 32'hff);
    rdFlash(20'h5, 16'h0);
    vppLow <= 1'b1;
    prog(20'h8, 16'h00ff);
    chkReg("status", OFF_STATUS, 32'h4e, 32'hff);
    vppLow <= 1'b0;
    rdFlash(20'h8, 16'hffff);
    setSeq({32'h0, 16'h0, 8'h0, CCFG, 8'h0, CUNLK, 8'h0, CUNLK}, 3'h4, 20'h0);
    go(OP_CFG, 2'h0);
    vppLow <= 1'b1;
    prog(20'h9, 16'h00ff);
    chkReg("status", OFF_STATUS, 32'he, 32'hff);
    vppLow <= 1'b0;
    $display("test reset and supply finished");
    ahbW(OFF_SEQCNT, 32'h7);
    chkReg("seq count", OFF_SEQCNT, 32'h6, 32'h7);
    ahbW(OFF_CTRL, {28'h0, OP_READ, 1'b1});
    ahbW(OFF_CTRL, 32'h10);
    chkReg("control", OFF_CTRL, 32'h4, 32'h3ff);
    chkReg("flash data", OFF_RDATA, 32'hffff, 32'hffff);
    $display("test bus rules finished");
    stop_test();
  end
endmodule
